/* cesel_defs.vh */
`ifndef CESEL_DEFS_VH
`define CESEL_DEFS_VH

// Register byte offset on APB
`define CESEL_ADDR_EDGE_SEL   12'h000
// Register reset value
`define CESEL_RST_EDGE_SEL    8'h00
// Field positions (low bit of each 2-bit field)
`define CESEL_FLD_CAP0        0
`define CESEL_FLD_CAP1        2
`define CESEL_FLD_CAP2        4
`define CESEL_FLD_CAP3        6
// Edge codes
`define CESEL_EDGE_NONE       2'b00
`define CESEL_EDGE_RISE       2'b01
`define CESEL_EDGE_FALL       2'b10
`define CESEL_EDGE_BOTH       2'b11

`endif

/* cesel_sync.v */
`timescale 1ns/1ns
`default_nettype none

module cesel_sync #(
   parameter WIDTH = 4
) (
   // Clock and reset
   input  wire             pclk,
   input  wire             presetn,
   // Asynchronous inputs and their synchronised copies
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] stage1;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= {WIDTH{1'b0}};
         dout   <= {WIDTH{1'b0}};
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule // cesel_sync

`default_nettype wire

/* cesel_edge.v */
`timescale 1ns/1ns
`default_nettype none
`include "cesel_defs.vh"

module cesel_edge (
   // Clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // Synchronised level and edge code
   input  wire       level,
   input  wire [1:0] mode,
   // One-cycle trigger
   output reg        trig
);

   reg  prev;
   wire rise;
   wire fall;

   assign rise = level & ~prev;
   assign fall = ~level & prev;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b0;
         trig <= 1'b0;
      end else begin
         prev <= level;
         case (mode)
            // R1: disabled, no trigger
            `CESEL_EDGE_NONE: trig <= 1'b0;
            // R2: rising only
            `CESEL_EDGE_RISE: trig <= rise;
            // R3: falling only
            `CESEL_EDGE_FALL: trig <= fall;
            // R4: both edges
            `CESEL_EDGE_BOTH: trig <= rise | fall;
            default:          trig <= 1'b0;
         endcase
      end
   end

endmodule // cesel_edge

`default_nettype wire

/* cesel_top.v */
// Contract
// R1: code 00 disables capture trigger
// R2: code 01 selects rising edge
// R3: code 10 selects falling edge
// R4: code 11 selects both edges
// R5: bits 7:6 steer capture input 3
// R6: bits 5:4 steer capture input 2
// R7: bits 3:2 steer capture input 1
// R8: bits 1:0 steer capture input 0
// R9: reset clears register to zero
// R10: register readable and writable, byte or bit
// R11: synchronise inputs, one-cycle pulse per edge
`timescale 1ns/1ns
`default_nettype none
`include "cesel_defs.vh"

module cesel_top (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Capture pins
   input  wire        capture_input_0,
   input  wire        capture_input_1,
   input  wire        capture_input_2,
   input  wire        capture_input_3,
   // Trigger pulses to capture logic
   output wire [3:0]  capture_trigger
);

   // Register map and reset image
   localparam [11:0]  ADDR_EDGE_SEL = `CESEL_ADDR_EDGE_SEL;
   localparam [7:0]   RST_EDGE_SEL  = `CESEL_RST_EDGE_SEL;
   // Number of capture inputs
   localparam integer NCAP          = 4;
   // Bus handshake states, one-hot
   localparam [1:0]   ST_IDLE       = 2'b01;
   localparam [1:0]   ST_ACCESS     = 2'b10;

   // Handshake state
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   // Bus answer, next values
   reg  [31:0] next_prdata;
   reg         next_pready;
   reg         next_pslverr;
   // Edge-select register
   reg  [7:0]  capture_edge_select;
   reg  [7:0]  next_edge_select;
   // Bus decode
   wire        setup;
   wire        hit;
   wire        take_setup;
   wire        rd_setup;
   wire        wr_done;
   wire [7:0]  wr_byte;
   wire [31:0] rd_word;
   // Pins and field codes
   wire [3:0]  pins_raw;
   wire [3:0]  pins_sync;
   wire [7:0]  edge_mode;
   wire        cap0_edge_lo;
   wire        cap0_edge_hi;
   wire        cap1_edge_lo;
   wire        cap1_edge_hi;
   wire        cap2_edge_lo;
   wire        cap2_edge_hi;
   wire        cap3_edge_lo;
   wire        cap3_edge_hi;
   genvar      i;

   // Setup phase: select high, enable still low
   assign setup      = psel & ~penable;
   assign hit        = (paddr[11:2] == ADDR_EDGE_SEL[11:2]);
   assign take_setup = setup & (state == ST_IDLE);
   assign rd_setup   = take_setup & hit & ~pwrite;
   // R10: write lands at the edge that ends the access
   assign wr_done    = psel & penable & pready & hit & pwrite & pstrb[0];
   assign wr_byte    = pwdata[7:0];
   // R10: byte read, upper bits zero
   assign rd_word    = {24'h00_0000, capture_edge_select};

   // One access cycle after every setup
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (setup) begin
               next_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @* begin
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (take_setup) begin
         next_pready  = 1'b1;
         next_pslverr = ~hit;
      end
      if (rd_setup) begin
         next_prdata = rd_word;
      end
   end

   // Single bits are set by read-modify-write
   always @* begin
      next_edge_select = capture_edge_select;
      if (wr_done) begin
         next_edge_select = wr_byte;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= ST_IDLE;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         state   <= next_state;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // R9: reset to zero
         capture_edge_select <= RST_EDGE_SEL;
      end else begin
         capture_edge_select <= next_edge_select;
      end
   end

   // R8: bits 1:0, input 0
   assign cap0_edge_lo = capture_edge_select[`CESEL_FLD_CAP0];
   assign cap0_edge_hi = capture_edge_select[`CESEL_FLD_CAP0+1];
   // R7: bits 3:2, input 1
   assign cap1_edge_lo = capture_edge_select[`CESEL_FLD_CAP1];
   assign cap1_edge_hi = capture_edge_select[`CESEL_FLD_CAP1+1];
   // R6: bits 5:4, input 2
   assign cap2_edge_lo = capture_edge_select[`CESEL_FLD_CAP2];
   assign cap2_edge_hi = capture_edge_select[`CESEL_FLD_CAP2+1];
   // R5: bits 7:6, input 3
   assign cap3_edge_lo = capture_edge_select[`CESEL_FLD_CAP3];
   assign cap3_edge_hi = capture_edge_select[`CESEL_FLD_CAP3+1];

   assign edge_mode = {cap3_edge_hi, cap3_edge_lo, cap2_edge_hi, cap2_edge_lo,
                       cap1_edge_hi, cap1_edge_lo, cap0_edge_hi, cap0_edge_lo};
   assign pins_raw  = {capture_input_3, capture_input_2, capture_input_1, capture_input_0};

   cesel_sync #(
      .WIDTH (NCAP)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      // R11: two-stage pin synchroniser
      .din     (pins_raw),
      .dout    (pins_sync)
   );

   // One edge selector per capture input
   generate
      for (i = 0; i < NCAP; i = i + 1) begin : g_edge
         cesel_edge u_edge (
            .pclk    (pclk),
            .presetn (presetn),
            .level   (pins_sync[i]),
            .mode    (edge_mode[2*i+1:2*i]),
            .trig    (capture_trigger[i])
         );
      end
   endgenerate

endmodule // cesel_top

`default_nettype wire

/* cesel_pins.sv */
`timescale 1ns/1ns
`default_nettype none
module cesel_pins (
   // Clock
   input  wire logic       pclk,
   // Levels asked for and pins driven
   input  wire logic [3:0] want,
   output logic      [3:0] pin = 4'h0
);
   always @(posedge pclk) pin <= want;
endmodule // cesel_pins
`default_nettype wire

/* cesel_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module cesel_sva (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Capture pins and triggers
   input wire logic        capture_input_0,
   input wire logic        capture_input_1,
   input wire logic        capture_input_2,
   input wire logic        capture_input_3,
   input wire logic [3:0]  capture_trigger
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] g;
   logic [3:0] s1, s2, s3;
   wire st = psel && !penable;
   wire m = paddr[11:2] == 0;
   wire [3:0] er = s2 & ~s3 & {g[6], g[4], g[2], g[0]};
   wire [3:0] ef = s3 & ~s2 & {g[7], g[5], g[3], g[1]};
   always @(posedge pclk or negedge presetn)
      if (!presetn) {g, s1, s2, s3} <= 20'h0;
      else begin
         if (psel && penable && pready && m && pwrite && pstrb[0]) g <= pwdata[7:0];
         {s3, s2, s1} <= {s2, s1, capture_input_3, capture_input_2,
            capture_input_1, capture_input_0};
      end
   a_ready_pulse: assert property (st |=> pready) else $error("late");
   a_ready_once: assert property (pready |=> !pready) else $error("long");
   a_err_unmap: assert property (st && !m |=> pslverr) else $error("err");
   a_read_value: assert property (st && m && !pwrite |=> prdata == {24'h0, g})
      else $error("data");
   a_rise_trig: assert property (er != 0 |=> (capture_trigger & $past(er)) == $past(er))
      else $error("rise");
   a_fall_trig: assert property (ef != 0 |=> (capture_trigger & $past(ef)) == $past(ef))
      else $error("fall");
   a_no_spurious: assert property (1 |=> capture_trigger == $past(er | ef))
      else $error("trig");
   a_pulse_one: assert property (capture_trigger != 0 |=>
      (capture_trigger & $past(capture_trigger) & ~$past(s2 ^ s3)) == 0) else $error("wide");
   c_read: cover property (st && !pwrite);
   c_write: cover property (psel && penable && pready && pwrite);
   c_err: cover property (pslverr);
   c_trig: cover property (capture_trigger != 0);
endmodule // cesel_sva
bind cesel_top cesel_sva chk (.*);
`default_nettype wire

/* cesel_test.sv */
`timescale 1ns/1ns
`default_nettype none
module cesel_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, v = 32'h17309216;
   logic [3:0] pstrb = 4'hf, want = 0;
   logic [7:0] r = 0;
   logic [3:0] ex = 0, tx = 0;
   logic [3:0] tq[$];
   logic [32:0] q[$];
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [3:0] capture_trigger, pin;
   int miscompares = 0, n_checks = 0, cyc = 0;
   cesel_top dut (.*, .capture_input_0(pin[0]), .capture_input_1(pin[1]),
      .capture_input_2(pin[2]), .capture_input_3(pin[3]));
   cesel_pins far (.*);
   always #25 pclk = ~pclk;
   function logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) $display("ERROR %0t %h %h", $time, seen, exp);
      if (seen !== exp) miscompares++;
   endtask
   task complete_run;
      $display("%0d checks %0d bad", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [32:0] e);
      q.push_back(e);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   always @(posedge pclk) if (pready === 1'b1) check({pslverr, prdata}, q.pop_front());
   always @(posedge pclk) if (capture_trigger !== 4'h0) begin
      tx = (tq.size() > 0) ? tq.pop_front() : 4'h0;
      check({29'h0, capture_trigger}, {29'h0, tx});
   end
   always @(posedge pclk) if (++cyc == 3000) begin
      miscompares++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      xfer(0, 12'h000, 33'h0);
      xfer(0, 12'hffc, {1'b1, 32'h0});
      xfer(1, 12'hffc, {1'b1, 32'h0});
      xfer(0, 12'h000, 33'h0);
      $display("regs done");
      repeat (40) begin
         v = nx(v);
         // Low strobe leaves old value
         pstrb <= {3'h7, v[8]};
         if (v[8]) r = v[7:0];
         xfer(1, 12'h000, 33'h0);
         xfer(0, 12'h000, {25'h0, r});
         repeat (8) begin
            v = nx(v);
            ex = (v[3:0] & ~want & {r[6], r[4], r[2], r[0]})
               | (~v[3:0] & want & {r[7], r[5], r[3], r[1]});
            if (ex != 4'h0) tq.push_back(ex);
            want <= v[3:0];
            repeat (3) @(posedge pclk);
         end
      end
      repeat (4) @(posedge pclk);
      check(33'(tq.size()), 33'h0);
      $display("edges done");
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      r = 8'h00;
      @(posedge pclk);
      xfer(0, 12'h000, 33'h0);
      $display("reset done");
      complete_run;
   end
endmodule // cesel_test
`default_nettype wire
